// ===== design/ssel_pkg.sv
// Constants shared by the speed reference selector: register map,
// field positions, reset values, scaling codes and frequency limits.
// Assumes frequencies in 0.1 Hz steps and currents in 0.1 mA steps.
package ssel_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LIMIT = 8'h04;
  localparam logic [7:0] A_PRE12 = 8'h08;
  localparam logic [7:0] A_PRE3 = 8'h0C;
  localparam logic [7:0] A_XMA = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;

  // Control register bit positions.
  localparam int B_PRE_EN = 0;
  localparam int B_PRE3 = 1;
  localparam int B_SWAP = 2;
  localparam int B_INV = 3;
  localparam int B_CLAMP = 4;
  localparam int B_AM_EN = 5;
  localparam int B_AR_EN = 6;
  localparam int B_KEYPAD = 7;
  localparam int B_SCL = 8;
  localparam int B_VSW = 10;
  localparam int B_STOP = 11;
  localparam int B_SHUT = 13;
  localparam int CTRL_W = 14;

  // Upper field position in two-value words, and status bits.
  localparam int F_HI = 16;
  localparam int S_REV = 16;
  localparam int S_RUN = 17;
  localparam int S_AUTO = 18;
  localparam int S_REJ = 19;

  // Reset values: clamp sum on, 4-20 mA scaling.
  localparam logic [13:0] CTRL_RST = 14'h0110;
  localparam logic [9:0] LOW_RST = 10'h000;
  localparam logic [9:0] HIGH_RST = 10'h258;
  localparam logic [9:0] P1_RST = 10'h032;
  localparam logic [9:0] P2_RST = 10'h064;
  localparam logic [9:0] P3_RST = 10'h096;
  localparam logic [7:0] XMA_RST = 8'h00;

  // Frequency and input code limits.
  localparam logic [9:0] FMAX = 10'h2D0;
  localparam logic [9:0] PMIN = 10'h001;
  localparam logic [9:0] VFULL = 10'h3FF;
  localparam logic [7:0] IFULL = 8'hC8;
  localparam logic [7:0] I4MA = 8'h28;
  localparam logic [7:0] ISPAN = 8'hA0;

  // Controlled stop command modes.
  localparam logic [1:0] STOP_LI = 2'h1;
  localparam logic [1:0] STOP_FQ = 2'h2;
  localparam logic [1:0] STOP_BOTH = 2'h3;

  // Current input scaling modes.
  typedef enum logic [1:0] {
    SSEL_S0_20 = 2'h0,
    SSEL_S4_20 = 2'h1,
    SSEL_S20_4 = 2'h2,
    SSEL_SX_20 = 2'h3
  } ssel_scale_t;

endpackage : ssel_pkg

// ===== design/ssel_top.sv
// Speed reference selector: presets, analog scaling and summing,
// Auto/Manual switching, with an APB register slave.
// Assumes analog codes come from converters on pclk; logic inputs are pins.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - First inputs fixed: run enable, run forward.
// - Incompatible function selection refused, flagged.
// - Shutdown refused with frequency-threshold stops.
// - One preset uses one input; three use two.
// - Presets 0.1..72 Hz; output capped at high.
// - Presets accepted only strictly increasing.
// - Inputs a,b select reference or presets 1-3.
// - Defaults 5 Hz; three presets 5,10,15.
// - Single preset runs while its input high.
// - Analog inputs assignable as reference one/two.
// - Current scaling 0-20, 4-20, 20-4, x-20.
// - x-20: span times current/20 plus low.
// - Voltage switch requires 0-20 scaling.
// - Voltage input fixed 0 to 10 V.
// - References summed, capped; Auto/Manual uses one.
// - Invert subtracts current from voltage reference.
// - Clamp sum: non-positive difference gives low.
// - No clamp: negative difference reverses motor.
// - Keypad mode freezes rotation direction.
// - 20-4 broken wire runs at high speed.
// - Auto high selects reference two alone.
// - Auto run input honoured only in auto.
// - Command clamped between low and high speed.
module ssel_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_enable_input,
  input wire logic run_forward_input,
  input wire logic assignable_input_a,
  input wire logic assignable_input_b,
  input wire logic [9:0] voltage_reference_input,
  input wire logic [7:0] current_reference_input,
  output logic [9:0] command_freq,
  output logic command_reverse,
  output logic run_command,
  output logic config_reject
);

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [13:0] ctrl_r;
  logic [9:0] low_r;
  logic [9:0] high_r;
  logic [9:0] p1_r;
  logic [9:0] p2_r;
  logic [9:0] p3_r;
  logic [7:0] xma_r;
  logic rej_r;
  logic [31:0] prdata_r;
  logic [9:0] freq_r;
  logic [9:0] freq_nxt;
  logic rev_r;
  logic rev_nxt;
  logic run_r;
  logic run_nxt;
  logic en_s;
  logic fwd_s;
  logic a_s;
  logic b_s;
  logic wr;
  logic mapped;
  logic bad_ctrl;
  logic bad_pre12;
  logic bad_pre3;
  logic bad_lim;
  logic bad_xma;
  logic w1c;
  logic auto_act;
  logic [9:0] span;
  logic [9:0] vc;
  logic [9:0] ic;
  logic [7:0] inum;
  logic [19:0] vprod;
  logic [17:0] iprod;
  logic signed [11:0] sum;
  logic [10:0] mag;
  logic rev_ref;
  logic pre_on;
  logic [9:0] pre_val;
  logic [10:0] fraw;

  // Keeps a value between low and high speed.
  function automatic logic [9:0] lim(input logic [10:0] f, input logic [9:0] lo,
                                     input logic [9:0] hi);
    logic [9:0] r;
    r = (f > {1'b0, hi}) ? hi : f[9:0];
    return (r < lo) ? lo : r;
  endfunction : lim

  // Counts assignable inputs used and checks pairwise compatibility.
  function automatic logic ctrl_bad(input logic [13:0] c);
    logic [2:0] n;
    n = 3'h0;
    if (c[ssel_pkg::B_PRE_EN])
      n = c[ssel_pkg::B_PRE3] ? 3'h2 : 3'h1;
    n = n + {2'h0, c[ssel_pkg::B_AM_EN]} + {2'h0, c[ssel_pkg::B_AR_EN]};
    if (c[ssel_pkg::B_STOP+:2] == ssel_pkg::STOP_LI || c[ssel_pkg::B_STOP+:2] == ssel_pkg::STOP_BOTH)
      n = n + 3'h1;
    return (n > 3'h2)
      || (c[ssel_pkg::B_SHUT] && c[ssel_pkg::B_STOP+:2] >= ssel_pkg::STOP_FQ)
      || (c[ssel_pkg::B_VSW] && c[ssel_pkg::B_SCL+:2] != ssel_pkg::SSEL_S0_20)
      || (c[ssel_pkg::B_AR_EN] && !c[ssel_pkg::B_AM_EN]);
  endfunction : ctrl_bad

  // Two-flop synchronisers for the four logic input pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {run_enable_input, run_forward_input, assignable_input_a, assignable_input_b};
      sync2_r <= sync1_r;
    end
  end

  assign en_s = sync2_r[3];
  assign fwd_s = sync2_r[2];
  assign a_s = sync2_r[1];
  assign b_s = sync2_r[0];

  // Bus decode and the validity checks on each kind of write.
  assign wr = psel && penable && pwrite;
  assign mapped = paddr inside {ssel_pkg::A_CTRL, ssel_pkg::A_LIMIT, ssel_pkg::A_PRE12,
                                ssel_pkg::A_PRE3, ssel_pkg::A_XMA, ssel_pkg::A_STAT};
  assign bad_ctrl = ctrl_bad(pwdata[13:0]);
  assign bad_pre12 = pwdata[9:0] < ssel_pkg::PMIN || pwdata[9:0] >= pwdata[25:16]
                     || pwdata[25:16] >= p3_r;
  assign bad_pre3 = pwdata[9:0] <= p2_r || pwdata[9:0] > ssel_pkg::FMAX;
  assign bad_lim = pwdata[9:0] > pwdata[25:16] || pwdata[25:16] > ssel_pkg::FMAX;
  assign bad_xma = pwdata[7:0] > ssel_pkg::IFULL;
  assign w1c = wr && paddr == ssel_pkg::A_STAT && pwdata[ssel_pkg::S_REJ];

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Control register; an illegal combination is not stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= ssel_pkg::CTRL_RST;
    else if (wr && paddr == ssel_pkg::A_CTRL && !bad_ctrl)
      ctrl_r <= pwdata[13:0];
  end

  // Speed limits and the programmable x current.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_r <= ssel_pkg::LOW_RST;
      high_r <= ssel_pkg::HIGH_RST;
      xma_r <= ssel_pkg::XMA_RST;
    end
    else if (wr && paddr == ssel_pkg::A_LIMIT && !bad_lim)
    begin
      low_r <= pwdata[9:0];
      high_r <= pwdata[25:16];
    end
    else if (wr && paddr == ssel_pkg::A_XMA && !bad_xma)
      xma_r <= pwdata[7:0];
  end

  // Preset speeds, factory values 5, 10 and 15 Hz.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p1_r <= ssel_pkg::P1_RST;
      p2_r <= ssel_pkg::P2_RST;
      p3_r <= ssel_pkg::P3_RST;
    end
    else if (wr && paddr == ssel_pkg::A_PRE12 && !bad_pre12)
    begin
      p1_r <= pwdata[9:0];
      p2_r <= pwdata[25:16];
    end
    else if (wr && paddr == ssel_pkg::A_PRE3 && !bad_pre3)
      p3_r <= pwdata[9:0];
  end

  // Sticky rejection flag; a new rejection wins over a clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rej_r <= 1'b0;
    else if (wr && ((paddr == ssel_pkg::A_CTRL && bad_ctrl)
             || (paddr == ssel_pkg::A_PRE12 && bad_pre12)
             || (paddr == ssel_pkg::A_PRE3 && bad_pre3)
             || (paddr == ssel_pkg::A_LIMIT && bad_lim)
             || (paddr == ssel_pkg::A_XMA && bad_xma)))
      rej_r <= 1'b1;
    else if (w1c)
      rej_r <= 1'b0;
  end

  // Read data is captured in the setup cycle of a read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ssel_pkg::A_CTRL: prdata_r <= {18'h0_0000, ctrl_r};
        ssel_pkg::A_LIMIT: prdata_r <= {6'h00, high_r, 6'h00, low_r};
        ssel_pkg::A_PRE12: prdata_r <= {6'h00, p2_r, 6'h00, p1_r};
        ssel_pkg::A_PRE3: prdata_r <= {22'h00_0000, p3_r};
        ssel_pkg::A_XMA: prdata_r <= {24'h00_0000, xma_r};
        ssel_pkg::A_STAT: prdata_r <= {12'h000, rej_r, auto_act, run_r, rev_r, 6'h00, freq_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Scales each analog input to a share of the low-to-high span.
  always_comb
  begin
    span = high_r - low_r;
    vprod = span * voltage_reference_input;
    vc = 10'(vprod / ssel_pkg::VFULL);
    unique case (ssel_pkg::ssel_scale_t'(ctrl_r[ssel_pkg::B_SCL+:2]))
      ssel_pkg::SSEL_S0_20: inum = current_reference_input;
      ssel_pkg::SSEL_S4_20: inum = (current_reference_input > ssel_pkg::I4MA)
                              ? current_reference_input - ssel_pkg::I4MA : 8'h00;
      ssel_pkg::SSEL_S20_4: inum = (current_reference_input < ssel_pkg::IFULL)
                              ? ssel_pkg::IFULL - current_reference_input : 8'h00;
      ssel_pkg::SSEL_SX_20: inum = (current_reference_input >= xma_r)
                              ? current_reference_input : 8'h00;
    endcase
    if (ctrl_r[ssel_pkg::B_SCL+:2] == ssel_pkg::SSEL_S4_20
        || ctrl_r[ssel_pkg::B_SCL+:2] == ssel_pkg::SSEL_S20_4)
    begin
      inum = (inum > ssel_pkg::ISPAN) ? ssel_pkg::ISPAN : inum;
      iprod = span * inum;
      ic = 10'(iprod / ssel_pkg::ISPAN);
    end
    else
    begin
      inum = (inum > ssel_pkg::IFULL) ? ssel_pkg::IFULL : inum;
      iprod = span * inum;
      ic = 10'(iprod / ssel_pkg::IFULL);
    end
  end

  // Combines the references: alone in Auto/Manual, else summed, or subtracted when invert is set.
  always_comb
  begin
    auto_act = ctrl_r[ssel_pkg::B_AM_EN] && (ctrl_r[ssel_pkg::B_PRE_EN] ? b_s : a_s);
    rev_ref = 1'b0;
    mag = 11'h000;
    if (ctrl_r[ssel_pkg::B_AM_EN])
    begin
      if (auto_act ^ ctrl_r[ssel_pkg::B_SWAP])
        mag = {1'b0, ic};
      else
        mag = {1'b0, vc};
      sum = 12'sh000;
    end
    else
    begin
      sum = ctrl_r[ssel_pkg::B_INV] ? $signed({2'h0, vc}) - $signed({2'h0, ic})
                                   : $signed({2'h0, vc}) + $signed({2'h0, ic});
      if (sum > 12'sh000)
        mag = 11'(sum);
      else if (sum < 12'sh000 && !ctrl_r[ssel_pkg::B_CLAMP])
      begin
        mag = 11'(-sum);
        rev_ref = 1'b1;
      end
      else
        mag = 11'h000;
    end
  end

  // Preset selection from the assignable inputs.
  always_comb
  begin
    pre_on = 1'b0;
    pre_val = ssel_pkg::P1_RST;
    if (ctrl_r[ssel_pkg::B_PRE_EN] && ctrl_r[ssel_pkg::B_PRE3])
    begin
      pre_on = a_s || b_s;
      unique case ({b_s, a_s})
        2'b01: pre_val = p1_r;
        2'b10: pre_val = p2_r;
        default: pre_val = p3_r;
      endcase
    end
    else if (ctrl_r[ssel_pkg::B_PRE_EN])
    begin
      pre_on = a_s;
      pre_val = p1_r;
    end
  end

  // Final command, clamped to the speed limits, and run logic.
  always_comb
  begin
    fraw = pre_on ? {1'b0, pre_val} : 11'({1'b0, low_r} + mag);
    freq_nxt = lim(fraw, low_r, high_r);
    rev_nxt = ctrl_r[ssel_pkg::B_KEYPAD] ? rev_r : (!pre_on && rev_ref);
    run_nxt = en_s && (fwd_s
              || (ctrl_r[ssel_pkg::B_AR_EN] && auto_act && b_s));
  end

  // Output registers, updated on every clock edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_r <= ssel_pkg::LOW_RST;
      rev_r <= 1'b0;
      run_r <= 1'b0;
    end
    else
    begin
      freq_r <= freq_nxt;
      rev_r <= rev_nxt;
      run_r <= run_nxt;
    end
  end

  assign command_freq = freq_r;
  assign command_reverse = rev_r;
  assign run_command = run_r;
  assign config_reject = rej_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The command is one edge behind a limit write, so it is held against the limit it was clamped to.
  a_freq_cap_high: assert property (freq_r <= $past(high_r))
    else $error("command above high speed");
  a_freq_floor_low: assert property (freq_r >= $past(low_r))
    else $error("command below low speed");
  a_preset_order: assert property (p1_r < p2_r && p2_r < p3_r)
    else $error("presets not strictly increasing");
  a_shut_refused: assert property (wr && paddr == ssel_pkg::A_CTRL && pwdata[ssel_pkg::B_SHUT]
    && pwdata[ssel_pkg::B_STOP+:2] == ssel_pkg::STOP_FQ |=> $stable(ctrl_r) && rej_r)
    else $error("shutdown with threshold stop accepted");
  // The expected preset is taken with the limits of the selecting cycle, so a limit write cannot race it.
  a_three_preset: assert property (ctrl_r[ssel_pkg::B_PRE_EN] && ctrl_r[ssel_pkg::B_PRE3]
    && a_s && b_s |=> freq_r == $past(lim({1'b0, p3_r}, low_r, high_r)))
    else $error("preset three not selected");
  a_one_preset: assert property (ctrl_r[ssel_pkg::B_PRE_EN] && !ctrl_r[ssel_pkg::B_PRE3]
    && a_s |=> freq_r == $past(lim({1'b0, p1_r}, low_r, high_r)))
    else $error("single preset not applied");
  a_keypad_dir: assert property (ctrl_r[ssel_pkg::B_KEYPAD] && $past(ctrl_r[ssel_pkg::B_KEYPAD])
    |-> $stable(rev_r))
    else $error("direction changed in keypad mode");
  a_run_needs_en: assert property (run_r |-> $past(en_s))
    else $error("run without run enable");
  a_autorun_manual: assert property (!auto_act && !fwd_s |=> !run_r)
    else $error("auto run honoured in manual");
  a_clamp_reverse: assert property (ctrl_r[ssel_pkg::B_CLAMP] && !ctrl_r[ssel_pkg::B_KEYPAD]
    |=> !rev_r)
    else $error("reverse while sum clamped");

  c_three_preset: cover property (ctrl_r[ssel_pkg::B_PRE3] && a_s && b_s ##1 freq_r == p3_r);
  c_reverse: cover property (!ctrl_r[ssel_pkg::B_CLAMP] && rev_r);
  c_auto_run: cover property (auto_act && !fwd_s && run_r);
  c_reject: cover property ($rose(rej_r));

endmodule : ssel_top

`default_nettype wire

// ===== tb/ssel_far_model.sv
// Far-side model: remote switches and the two analog reference sources.
// Assumes the bench sets the wanted levels; the pins move one pclk edge later.
`timescale 1ns/1ps
`default_nettype none
module ssel_far_model (
  input wire logic pclk,
  input wire logic [3:0] sw_set,
  input wire logic [9:0] volt_set,
  input wire logic [7:0] curr_set,
  input wire logic wire_broken,
  output logic run_enable_input,
  output logic run_forward_input,
  output logic assignable_input_a,
  output logic assignable_input_b,
  output logic [9:0] voltage_reference_input,
  output logic [7:0] current_reference_input
);
  // Switch contacts follow the operator settings after a clock edge.
  always_ff @(posedge pclk)
  begin
    run_enable_input <= sw_set[0];
    run_forward_input <= sw_set[1];
    assignable_input_a <= sw_set[2];
    assignable_input_b <= sw_set[3];
  end
  // A broken current loop delivers no current whatever the source asks.
  always_ff @(posedge pclk)
  begin
    voltage_reference_input <= volt_set;
    current_reference_input <= wire_broken ? 8'h00 : curr_set;
  end
endmodule : ssel_far_model
`default_nettype wire

// ===== tb/speed_reference_selector_tb.sv
// Self-checking bench for the speed reference selector.
// Assumes the far-side model drives the pins and APB reaches the registers.
`timescale 1ns/1ps
`default_nettype none
module speed_reference_selector_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rsp_err;
  logic [3:0] sw_set = 4'h0;
  logic [9:0] volt_set = 10'h000;
  logic [7:0] curr_set = 8'h00;
  logic wire_broken = 1'b0;
  logic en_w, fwd_w, a_w, b_w;
  logic [9:0] v_w;
  logic [7:0] i_w;
  logic [9:0] command_freq;
  logic command_reverse, run_command, config_reject;
  int error_cnt = 0;
  int num_checks = 0;

  // Clock at 200 MHz.
  always #2.5 pclk = ~pclk;

  ssel_far_model u_far (.pclk(pclk), .sw_set(sw_set), .volt_set(volt_set), .curr_set(curr_set),
    .wire_broken(wire_broken), .run_enable_input(en_w), .run_forward_input(fwd_w),
    .assignable_input_a(a_w), .assignable_input_b(b_w), .voltage_reference_input(v_w),
    .current_reference_input(i_w));

  ssel_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_enable_input(en_w), .run_forward_input(fwd_w), .assignable_input_a(a_w),
    .assignable_input_b(b_w), .voltage_reference_input(v_w), .current_reference_input(i_w),
    .command_freq(command_freq), .command_reverse(command_reverse), .run_command(run_command),
    .config_reject(config_reject));

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      error_cnt++;
      summarize();
    end
    q = prdata;
    rsp_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rdchk

  // Lets pin synchronisers and the speed path settle, then checks the command.
  task automatic fchk(input logic [9:0] exp);
    repeat (6) @(posedge pclk);
    chk({22'h00_0000, command_freq}, {22'h00_0000, exp});
  endtask : fchk

  task automatic sc_reset();
    rdchk(ssel_pkg::A_CTRL, 32'h0000_0110);
    rdchk(ssel_pkg::A_LIMIT, 32'h0258_0000);
    rdchk(ssel_pkg::A_PRE12, 32'h0064_0032);
    rdchk(ssel_pkg::A_PRE3, 32'h0000_0096);
    rdchk(8'h40, 32'h0000_0000);
    chk({31'h0, rsp_err}, 32'h0000_0001);
    chk({31'h0, pready}, 32'h0000_0001);
    chk({31'h0, run_command}, 32'h0000_0000);
  endtask : sc_reset

  task automatic sc_presets();
    wr(ssel_pkg::A_CTRL, 32'h0000_0113);
    sw_set <= 4'b0011;
    fchk(10'h000);
    sw_set <= 4'b0111;
    fchk(10'h032);
    sw_set <= 4'b1011;
    fchk(10'h064);
    sw_set <= 4'b1111;
    fchk(10'h096);
    wr(ssel_pkg::A_LIMIT, 32'h0078_0000);
    fchk(10'h078);
    wr(ssel_pkg::A_LIMIT, 32'h0258_0000);
    wr(ssel_pkg::A_CTRL, 32'h0000_0111);
    sw_set <= 4'b0111;
    fchk(10'h032);
    sw_set <= 4'b0011;
    fchk(10'h000);
  endtask : sc_presets

  task automatic sc_refuse();
    wr(ssel_pkg::A_PRE12, 32'h0032_0064);
    rdchk(ssel_pkg::A_PRE12, 32'h0064_0032);
    chk({31'h0, config_reject}, 32'h0000_0001);
    wr(ssel_pkg::A_STAT, 32'h0008_0000);
    @(posedge pclk);
    chk({31'h0, config_reject}, 32'h0000_0000);
    wr(ssel_pkg::A_CTRL, 32'h0000_3110);
    rdchk(ssel_pkg::A_CTRL, 32'h0000_0111);
    wr(ssel_pkg::A_STAT, 32'h0008_0000);
    wr(ssel_pkg::A_CTRL, 32'h0000_0510);
    rdchk(ssel_pkg::A_CTRL, 32'h0000_0111);
    chk({31'h0, config_reject}, 32'h0000_0001);
    wr(ssel_pkg::A_STAT, 32'h0008_0000);
  endtask : sc_refuse

  task automatic sc_sum();
    wr(ssel_pkg::A_LIMIT, 32'h0258_0064);
    wr(ssel_pkg::A_CTRL, 32'h0000_0010);
    fchk(10'h064);
    curr_set <= 8'd100;
    fchk(10'h15E);
    volt_set <= 10'h3FF;
    fchk(10'h258);
    wr(ssel_pkg::A_CTRL, 32'h0000_0018);
    volt_set <= 10'h000;
    fchk(10'h064);
    chk({31'h0, command_reverse}, 32'h0000_0000);
    wr(ssel_pkg::A_CTRL, 32'h0000_0008);
    fchk(10'h15E);
    chk({31'h0, command_reverse}, 32'h0000_0001);
    wr(ssel_pkg::A_CTRL, 32'h0000_0088);
    curr_set <= 8'd0;
    volt_set <= 10'h3FF;
    fchk(10'h258);
    chk({31'h0, command_reverse}, 32'h0000_0001);
    rdchk(ssel_pkg::A_STAT, 32'h0003_0258);
  endtask : sc_sum

  task automatic sc_scaling();
    volt_set <= 10'h000;
    wr(ssel_pkg::A_CTRL, 32'h0000_0110);
    fchk(10'h064);
    wr(ssel_pkg::A_CTRL, 32'h0000_0210);
    wire_broken <= 1'b1;
    fchk(10'h258);
    wire_broken <= 1'b0;
    wr(ssel_pkg::A_XMA, 32'h0000_0064);
    wr(ssel_pkg::A_CTRL, 32'h0000_0310);
    curr_set <= 8'd50;
    fchk(10'h064);
    curr_set <= 8'd200;
    fchk(10'h258);
  endtask : sc_scaling

  task automatic sc_auto();
    wr(ssel_pkg::A_CTRL, 32'h0000_0030);
    volt_set <= 10'h3FF;
    curr_set <= 8'd100;
    sw_set <= 4'b0011;
    fchk(10'h258);
    sw_set <= 4'b0111;
    fchk(10'h15E);
    wr(ssel_pkg::A_CTRL, 32'h0000_0034);
    sw_set <= 4'b0011;
    fchk(10'h15E);
    wr(ssel_pkg::A_CTRL, 32'h0000_0070);
    sw_set <= 4'b1101;
    fchk(10'h15E);
    chk({31'h0, run_command}, 32'h0000_0001);
    rdchk(ssel_pkg::A_STAT, 32'h0006_015E);
    sw_set <= 4'b1001;
    fchk(10'h258);
    chk({31'h0, run_command}, 32'h0000_0000);
    sw_set <= 4'b0010;
    fchk(10'h258);
    chk({31'h0, run_command}, 32'h0000_0000);
    rdchk(ssel_pkg::A_STAT, 32'h0000_0258);
  endtask : sc_auto

  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_presets();
    sc_refuse();
    sc_sum();
    sc_scaling();
    sc_auto();
    summarize();
  end
endmodule : speed_reference_selector_tb
`default_nettype wire
